// [hdl/instr_exec_defines.svh]
`ifndef INSTR_EXEC_DEFINES_SVH
`define INSTR_EXEC_DEFINES_SVH

// ------------------------------------------------------------------
// Instruction word layout
// ------------------------------------------------------------------
`define IW_WIDTH 14
`define OPC_MSB 13
`define OPC_LSB 8
`define DEST_BIT 7
`define REG_MSB 6
`define LIT_MSB 7

// ------------------------------------------------------------------
// Opcode patterns (bits 13..8)
// ------------------------------------------------------------------
`define OPC_INC_SKIP_ZERO 6'h0f
`define OPC_OR_LITERAL 6'h1a
`define OPC_OR_ACC_REG 6'h04
`define OPC_MOVE_REG 6'h08
`define OPC_MOVE_LITERAL 6'h19

// ------------------------------------------------------------------
// Destination encoding and reset values
// ------------------------------------------------------------------
`define DEST_ACC 1'h0
`define DEST_FILE 1'h1
`define ACC_RESET 8'h00
`define ZERO_RESET 1'h0
`define REG_ADDR_RESET 7'h00

`endif

// [hdl/instr_exec_pkg.sv]
package instr_exec_pkg;

   // Decoded operation of the current instruction word.
   typedef enum logic [2:0] {
      OP_NONE,
      OP_INC_SKIP_ZERO,
      OP_OR_LITERAL,
      OP_OR_ACC_REG,
      OP_MOVE_REG,
      OP_MOVE_LITERAL
   } op_kind_t;

   // Execution phase: normal issue, or a forced no-op after a skip.
   typedef enum logic {
      ST_RUN,
      ST_SKIP
   } exec_state_t;

endpackage

// [hdl/instr_classify.sv]
`timescale 1ns/1ps
`include "instr_exec_defines.svh"

// Maps an instruction word to the operation it requests.
module instr_classify (
   input wire logic [`IW_WIDTH-1:0] word_in,
   output instr_exec_pkg::op_kind_t kind_out
);
   import instr_exec_pkg::*;

   logic [5:0] opc;

   // ---------------------------------------------------------------
   // Opcode decode
   // ---------------------------------------------------------------

   // Top six bits select the operation; move from register also needs
   // bit 7 clear.
   always_comb begin
      opc = word_in[`OPC_MSB:`OPC_LSB];
      if (opc == `OPC_INC_SKIP_ZERO) begin
         kind_out = OP_INC_SKIP_ZERO;
      end else if (opc == `OPC_OR_LITERAL) begin
         kind_out = OP_OR_LITERAL;
      end else if (opc == `OPC_OR_ACC_REG) begin
         kind_out = OP_OR_ACC_REG;
      end else if (opc == `OPC_MOVE_REG &&
                   word_in[`DEST_BIT] == `DEST_ACC) begin
         kind_out = OP_MOVE_REG;
      end else if (opc == `OPC_MOVE_LITERAL) begin
         kind_out = OP_MOVE_LITERAL;
      end else begin
         kind_out = OP_NONE;
      end
   end

endmodule

// [hdl/increment_or_move_instr_exec.sv]
`timescale 1ns/1ps
`include "instr_exec_defines.svh"

// Notes on behaviour
// - Opcode 001111 d fffffff increments register, skips next if zero.
// - Zero result turns next instruction into a no-op: two cycles.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Register operands address file registers 00h to 7Fh only.
// - Opcode 011010 k: accumulator ORed with literal, one cycle, Z updated.
// - Opcode 000100 d f: accumulator OR register, to destination, Z updated.
// - Opcode 0010000 f copies register into accumulator; flags untouched.
// - Opcode 011001 k loads literal into accumulator; flags untouched.
module increment_or_move_instr_exec (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic instr_valid_in,
   input wire logic [`IW_WIDTH-1:0] instr_in,
   input wire logic [7:0] file_rd_data_in,
   output logic [6:0] file_addr_out,
   output logic file_wr_en_out,
   output logic [7:0] file_wr_data_out,
   output logic [7:0] acc_out,
   output logic zero_flag_out,
   output logic zero_wr_out,
   output logic skipped_out,
   output logic done_out
);
   import instr_exec_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------

   typedef struct packed {
      exec_state_t state;
      logic [6:0] addr;
      logic wr_en;
      logic [7:0] wr_data;
      logic [7:0] acc;
      logic zero;
      logic zero_wr;
      logic skipped;
      logic done;
   } exec_regs_t;

   // Registered state and the decoded fields of the current word.
   exec_regs_t state_reg;
   exec_regs_t state_next;
   op_kind_t kind;
   logic [6:0] reg_field;
   logic [7:0] literal;
   logic dest;
   logic [7:0] result;
   logic [7:0] operand;
   logic has_dest;
   logic sets_zero;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------

   instr_classify classify_inst (
      .word_in(instr_in),
      .kind_out(kind)
   );

   // The register field is seven bits wide, so the address can never
   // leave 00h..7Fh.
   assign reg_field = instr_in[`REG_MSB:0];
   assign literal = instr_in[`LIT_MSB:0];
   assign dest = instr_in[`DEST_BIT];

   // Only the increment and the OR with a register carry a destination
   // bit; only the two OR forms report a zero result.
   always_comb begin
      has_dest = 1'b0;
      sets_zero = 1'b0;
      case (kind)
         OP_INC_SKIP_ZERO: begin
            has_dest = 1'b1;
         end
         OP_OR_ACC_REG: begin
            has_dest = 1'b1;
            sets_zero = 1'b1;
         end
         OP_OR_LITERAL: begin
            sets_zero = 1'b1;
         end
         default: begin
            // Moves and unknown words leave both flags low.
            has_dest = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Operand select
   // ---------------------------------------------------------------

   // A write launched by the previous slot only reaches the file at
   // this edge, so the file still shows the old value. The pending
   // write is handed straight to the next instruction, which keeps
   // back-to-back increments of one counter from losing a count.
   always_comb begin
      if (state_reg.wr_en && state_reg.addr == reg_field) begin
         operand = state_reg.wr_data;
      end else begin
         operand = file_rd_data_in;
      end
   end

   // ---------------------------------------------------------------
   // Execute
   // ---------------------------------------------------------------

   // The register file answers the address combinationally, so the
   // read data belongs to the instruction presented this cycle. A slot
   // taken at one edge shows its results from that edge on; pulses
   // last one cycle and the accumulator and flag hold until changed.
   always_comb begin
      // Pulses fall back low each cycle; held values carry over.
      state_next = state_reg;
      state_next.wr_en = 1'b0;
      state_next.zero_wr = 1'b0;
      state_next.skipped = 1'b0;
      state_next.done = 1'b0;
      result = 8'h00;
      state_next.addr = reg_field;
      case (state_reg.state)
         ST_SKIP: begin
            // The word in the slot after a zero increment is dropped.
            // Idle cycles leave the skip armed; only a real slot is used.
            if (instr_valid_in) begin
               state_next.state = ST_RUN;
               state_next.skipped = 1'b1;
               state_next.done = 1'b1;
            end
         end
         default: begin
            if (instr_valid_in) begin
               state_next.done = 1'b1;
               case (kind)
                  OP_INC_SKIP_ZERO: begin
                     // Wraps from ffh to 00h, which arms the skip.
                     result = operand + 8'h01;
                     if (result == 8'h00) begin
                        state_next.state = ST_SKIP;
                     end
                  end
                  OP_OR_LITERAL: begin
                     // The literal is ORed in; the zero flag follows.
                     result = state_reg.acc | literal;
                  end
                  OP_OR_ACC_REG: begin
                     // The file operand may come from the pending write.
                     result = state_reg.acc | operand;
                  end
                  OP_MOVE_REG: begin
                     // Status flags are left alone by this move.
                     result = operand;
                  end
                  OP_MOVE_LITERAL: begin
                     // A plain load; status flags are left alone.
                     result = literal;
                  end
                  default: begin
                     // Unknown words take the slot and change nothing.
                     result = 8'h00;
                  end
               endcase
               // Results go to the accumulator or back to the file.
               if (has_dest) begin
                  if (dest == `DEST_FILE) begin
                     state_next.wr_en = 1'b1;
                     state_next.wr_data = result;
                  end else begin
                     state_next.acc = result;
                  end
               end else if (kind != OP_NONE) begin
                  state_next.acc = result;
               end
               // Only the two OR forms touch the zero flag; the increment
               // and both moves leave it as it was.
               if (sets_zero) begin
                  state_next.zero = (result == 8'h00);
                  state_next.zero_wr = 1'b1;
               end
            end
         end
      endcase
   end

   // Registers the whole state word.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         // Only constants here, so reset never depends on live data.
         state_reg.state <= ST_RUN;
         state_reg.addr <= `REG_ADDR_RESET;
         state_reg.wr_en <= 1'b0;
         state_reg.wr_data <= 8'h00;
         state_reg.acc <= `ACC_RESET;
         state_reg.zero <= `ZERO_RESET;
         state_reg.zero_wr <= 1'b0;
         state_reg.skipped <= 1'b0;
         state_reg.done <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------

   // Every output is a plain view of a register field, so nothing
   // downstream sees a combinational glitch.
   assign file_addr_out = state_reg.addr;
   assign file_wr_en_out = state_reg.wr_en;
   assign file_wr_data_out = state_reg.wr_data;
   assign acc_out = state_reg.acc;
   assign zero_flag_out = state_reg.zero;
   assign zero_wr_out = state_reg.zero_wr;
   assign skipped_out = state_reg.skipped;
   assign done_out = state_reg.done;

endmodule

// [verification/instr_exec_props.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port checks for the executor
// ------------------------------------------------------------------
module instr_exec_chk (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic instr_valid_in,
   input wire logic [13:0] instr_in,
   input wire logic [7:0] file_rd_data_in,
   input wire logic [6:0] file_addr_out,
   input wire logic file_wr_en_out,
   input wire logic [7:0] file_wr_data_out,
   input wire logic [7:0] acc_out,
   input wire logic zero_flag_out,
   input wire logic zero_wr_out,
   input wire logic skipped_out,
   input wire logic done_out
);
   logic [5:0] op;
   logic [7:0] k;
   logic [6:0] a;
   logic [7:0] f;
   logic v;
   logic inc_wrap;
   // Opcode, literal and register fields of the offered word.
   assign op = instr_in[13:8];
   assign k = instr_in[7:0];
   assign a = instr_in[6:0];
   assign v = instr_valid_in;
   // Register operand as the core must see it: a write still pending
   // for the same register stands in for the stale file value.
   assign f = (file_wr_en_out && file_addr_out == a) ? file_wr_data_out :
      file_rd_data_in;
   // An increment of ffh wraps to zero and must arm the skip.
   assign inc_wrap = op == 6'h0f && f == 8'hff;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   slot_done_a: assert property (v |=> done_out)
      else $error("slot not completed");
   idle_quiet_a: assert property (!v |=> !done_out)
      else $error("done without a slot");
   or_lit_a: assert property (v && op == 6'h1a |=> skipped_out ||
      acc_out == ($past(acc_out) | $past(k)) && zero_wr_out)
      else $error("literal or wrong");
   move_lit_a: assert property (v && op == 6'h19 |=> skipped_out ||
      acc_out == $past(k) && !zero_wr_out) else $error("literal load wrong");
   move_reg_a: assert property (v && instr_in[13:7] == 7'h10 |=>
      skipped_out || acc_out == $past(f) && !zero_wr_out)
      else $error("register move wrong");
   inc_acc_a: assert property (v && instr_in[13:7] == 7'h1e |=>
      skipped_out || acc_out == $past(f) + 8'h01 &&
      !file_wr_en_out) else $error("increment to acc wrong");
   inc_file_a: assert property (v && instr_in[13:7] == 7'h1f |=>
      skipped_out || file_wr_en_out && file_addr_out == $past(a) &&
      file_wr_data_out == $past(f) + 8'h01)
      else $error("increment to file wrong");
   skip_next_a: assert property (done_out && !skipped_out && v &&
      $past(inc_wrap) |=> skipped_out)
      else $error("skip missed");
   skip_quiet_a: assert property (skipped_out |-> !file_wr_en_out &&
      !zero_wr_out && $stable(acc_out)) else $error("skipped slot acted");
   zero_flag_a: assert property (zero_wr_out |-> zero_flag_out ==
      (file_wr_en_out ? file_wr_data_out == 8'h00 : acc_out == 8'h00))
      else $error("zero flag wrong");
   zero_hold_a: assert property (!zero_wr_out |->
      $stable(zero_flag_out)) else $error("zero flag moved");
endmodule

bind increment_or_move_instr_exec instr_exec_chk i_chk (
   .clk_in(clk_in),
   .rst_in(rst_in),
   .instr_valid_in(instr_valid_in),
   .instr_in(instr_in),
   .file_rd_data_in(file_rd_data_in),
   .file_addr_out(file_addr_out),
   .file_wr_en_out(file_wr_en_out),
   .file_wr_data_out(file_wr_data_out),
   .acc_out(acc_out),
   .zero_flag_out(zero_flag_out),
   .zero_wr_out(zero_wr_out),
   .skipped_out(skipped_out),
   .done_out(done_out)
);

// [verification/increment_or_move_instr_exec_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
   err_count++; $display("mismatch %s exp %h got %h", n, e, s); end end

module increment_or_move_instr_exec_tb;
   logic clk_in = 0, rst_in = 1, instr_valid_in = 0;
   logic [13:0] instr_in = 14'h0000;
   logic [7:0] file_rd_data_in, file_wr_data_out, acc_out, r, wd;
   logic [6:0] file_addr_out, wa;
   logic file_wr_en_out, zero_flag_out, zero_wr_out, skipped_out, done_out;
   logic [7:0] m [128];
   logic [7:0] mem [128];
   logic [7:0] acc = 8'h00;
   logic z = 0, skip = 0, e_done = 0, e_skip = 0, e_we = 0, e_zw = 0, ok;
   logic [5:0] ops [6] = '{6'h0f, 6'h1a, 6'h04, 6'h08, 6'h19, 6'h2a};
   logic [31:0] rnd;
   int err_count = 0, n_compared = 0, seed = 33276;
   // The file registers answer at once and take writes at the edge.
   assign file_rd_data_in = mem[instr_in[6:0]];
   always @(posedge clk_in) begin
      if (file_wr_en_out)
         mem[file_addr_out] <= file_wr_data_out;
   end
   // Free-running clock, 5 ns period.
   always #2.5 clk_in = ~clk_in;
   increment_or_move_instr_exec i_dut (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .instr_valid_in(instr_valid_in),
      .instr_in(instr_in),
      .file_rd_data_in(file_rd_data_in),
      .file_addr_out(file_addr_out),
      .file_wr_en_out(file_wr_en_out),
      .file_wr_data_out(file_wr_data_out),
      .acc_out(acc_out),
      .zero_flag_out(zero_flag_out),
      .zero_wr_out(zero_wr_out),
      .skipped_out(skipped_out),
      .done_out(done_out)
   );
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Offers one slot, checks the previous one, then models this one.
   task automatic step(input logic v, input logic [13:0] w);
      @(posedge clk_in);
      instr_valid_in <= v;
      instr_in <= w;
      @(negedge clk_in);
      `CHK("done", e_done, done_out)
      `CHK("skipped", e_skip, skipped_out)
      `CHK("wr_en", e_we, file_wr_en_out)
      `CHK("zero_wr", e_zw, zero_wr_out)
      `CHK("acc", acc, acc_out)
      `CHK("zero", z, zero_flag_out)
      if (e_we) begin
         `CHK("addr", wa, file_addr_out)
         `CHK("data", wd, file_wr_data_out)
      end
      e_done = v;
      e_skip = v && skip;
      skip = skip && !v;
      r = m[w[6:0]];
      ok = v && !e_skip && (w[13:7] == 7'h10 ||
         w[13:8] inside {6'h0f, 6'h1a, 6'h04, 6'h19});
      case (w[13:8])
         6'h0f: r = r + 8'h01;
         6'h04: r = acc | r;
         6'h1a: r = acc | w[7:0];
         6'h19: r = w[7:0];
         default: ;
      endcase
      e_zw = ok && w[13:8] inside {6'h04, 6'h1a};
      e_we = ok && w[7] && w[13:8] inside {6'h0f, 6'h04};
      if (e_zw)
         z = (r == 8'h00);
      if (ok && w[13:8] == 6'h0f)
         skip = (r == 8'h00);
      wa = w[6:0];
      wd = r;
      if (e_we)
         m[wa] = r;
      else if (ok)
         acc = r;
   endtask
   // Directed skip walk, then random slots with idle gaps.
   initial begin
      for (int i = 0; i < 128; i++) begin
         m[i] = {7'h7f, 1'($random(seed))};
         mem[i] = m[i];
      end
      m[5] = 8'hff;
      mem[5] = 8'hff;
      repeat (6) @(posedge clk_in);
      rst_in <= 0;
      step(1, 14'h0f85);
      step(0, 14'h0000);
      step(1, 14'h1a35);
      step(1, 14'h199a);
      step(1, 14'h1a35);
      // Back-to-back work on one register, then a move and an OR of it.
      step(1, 14'h0f85);
      step(1, 14'h0f05);
      step(1, 14'h0805);
      step(1, 14'h0485);
      repeat (600) begin
         rnd = $random(seed);
         step(rnd[1:0] != 2'h0, {ops[rnd[7:2] % 6], rnd[15:8]});
      end
      step(0, 14'h0000);
      end_of_test();
   end
   // Cuts the run short if the slot sequence hangs.
   initial begin
      #20000;
      err_count++;
      end_of_test();
   end
endmodule
